// File: core/serial_irq_ctrl.sv
// Purpose: pending and enable registers with one interrupt line for the
//          first serial controller, reached over AXI4-Lite
// Assumes: event inputs are synchronous to ref_clk, one cycle or longer
// Notes:   a high input in any cycle sets its pending flag
//          and a source held high keeps setting it
`timescale 1ns/10ps
module serial_irq_ctrl (
	input  wire logic                                ref_clk,
	input  wire logic                                rstn,
	// event sources
	input  wire logic                                uart_parity_error_event,
	input  wire logic                                uart_framing_error_event,
	input  wire logic                                tx_buffer_b_unloaded_event,
	input  wire logic                                tx_buffer_a_unloaded_event,
	input  wire logic                                rx_buffer_b_unloaded_event,
	input  wire logic                                rx_buffer_a_unloaded_event,
	input  wire logic                                i2c_not_acknowledged_event,
	input  wire logic                                i2c_command_done_event,
	input  wire logic                                i2c_transmit_done_event,
	input  wire logic                                i2c_receive_done_event,
	input  wire logic                                transmit_underrun_event,
	input  wire logic                                receive_overrun_event,
	input  wire logic                                transmitter_idle_event,
	input  wire logic                                transmit_space_event,
	input  wire logic                                receive_data_event,
	// AXI4-Lite write address
	input  wire logic [serial_irq_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                                s_axi_awvalid,
	output logic                                     s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [serial_irq_pkg::DATA_W-1:0]   s_axi_wdata,
	input  wire logic [serial_irq_pkg::STRB_W-1:0]   s_axi_wstrb,
	input  wire logic                                s_axi_wvalid,
	output logic                                     s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                               s_axi_bresp,
	output logic                                     s_axi_bvalid,
	input  wire logic                                s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [serial_irq_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                                s_axi_arvalid,
	output logic                                     s_axi_arready,
	// AXI4-Lite read data
	output logic [serial_irq_pkg::DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                               s_axi_rresp,
	output logic                                     s_axi_rvalid,
	input  wire logic                                s_axi_rready,
	// interrupt request toward the processor, active high level
	output logic                                     irqOut
);

	// ------------------------------------------------------------
	// address decode, used by both the read and the write path
	// ------------------------------------------------------------

	// true when a byte address falls in the word of a register
	// the two lane bits are masked, so a sub-word address still lands
	function automatic logic hitsReg(
		input logic [serial_irq_pkg::ADDR_W-1:0] addr,
		input logic [serial_irq_pkg::ADDR_W-1:0] offset
	);
		hitsReg = (addr & serial_irq_pkg::WORD_MASK) == offset;
	endfunction : hitsReg

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------

	logic rstnMeta_reg;  // first stage, read only by the second
	logic rstnSync_reg;  // reset used by the rest of the block

	// assert at once, release two edges later so no flop sees a
	// partial release
	// every other flop of the block except the payload capture resets from the released copy
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rstnMeta_reg <= 1'b0;
			rstnSync_reg <= 1'b0;
		end else begin
			rstnMeta_reg <= 1'b1;
			rstnSync_reg <= rstnMeta_reg;
		end
	end

	// ------------------------------------------------------------
	// event gathering
	// ------------------------------------------------------------

	logic [serial_irq_pkg::EVT_N-1:0] eventVec;     // sources at their bits
	logic [serial_irq_pkg::EVT_N-1:0] clearVec;     // write-one clears
	logic [serial_irq_pkg::EVT_N-1:0] pendingFlags; // sticky flags
	logic [serial_irq_pkg::EVT_N-1:0] enable_reg;   // per-source enable
	logic [serial_irq_pkg::EVT_N-1:0] enable_next;  // next enable value

	// each source sits at the same bit in pending and enable, so the
	// interrupt is one bitwise and; there is no edge detection here
	// uart error sources
	assign eventVec[serial_irq_pkg::BIT_UART_PARITY] = uart_parity_error_event;
	assign eventVec[serial_irq_pkg::BIT_UART_FRAME]  = uart_framing_error_event;
	// dma buffer unload sources
	assign eventVec[serial_irq_pkg::BIT_TX_B_UNLOAD] = tx_buffer_b_unloaded_event;
	assign eventVec[serial_irq_pkg::BIT_TX_A_UNLOAD] = tx_buffer_a_unloaded_event;
	assign eventVec[serial_irq_pkg::BIT_RX_B_UNLOAD] = rx_buffer_b_unloaded_event;
	assign eventVec[serial_irq_pkg::BIT_RX_A_UNLOAD] = rx_buffer_a_unloaded_event;
	// i2c sources
	assign eventVec[serial_irq_pkg::BIT_I2C_NAK] = i2c_not_acknowledged_event;
	assign eventVec[serial_irq_pkg::BIT_I2C_CMD] = i2c_command_done_event;
	assign eventVec[serial_irq_pkg::BIT_I2C_TX]  = i2c_transmit_done_event;
	assign eventVec[serial_irq_pkg::BIT_I2C_RX]  = i2c_receive_done_event;
	// fifo and serializer sources
	assign eventVec[serial_irq_pkg::BIT_TX_UNDERRUN] = transmit_underrun_event;
	assign eventVec[serial_irq_pkg::BIT_RX_OVERRUN]  = receive_overrun_event;
	assign eventVec[serial_irq_pkg::BIT_TX_IDLE]     = transmitter_idle_event;
	assign eventVec[serial_irq_pkg::BIT_TX_FREE]     = transmit_space_event;
	assign eventVec[serial_irq_pkg::BIT_RX_DATA]     = receive_data_event;

	// sticky flags; a set in the clearing cycle is kept
	event_flag_bank flagBank (
		.clk     (ref_clk),
		.rstn    (rstnSync_reg),
		.setIn   (eventVec),
		.clearIn (clearVec),
		.flags   (pendingFlags)
	);

	// one level line, high while any enabled flag is pending
	// combinational from flops, so it drops the cycle after a clear
	assign irqOut = |(pendingFlags & enable_reg);

	// ------------------------------------------------------------
	// write channel
	// ------------------------------------------------------------

	// write-side state; payload flops load only on their handshake
	logic                              awHeld_reg;  // address taken, waiting
	logic [serial_irq_pkg::ADDR_W-1:0] awAddr_reg;  // taken address
	logic                              wHeld_reg;   // data taken, waiting
	logic [serial_irq_pkg::DATA_W-1:0] wData_reg;   // taken data
	logic [serial_irq_pkg::STRB_W-1:0] wStrb_reg;   // taken strobes
	logic                              bValid_reg;  // response pending
	logic [1:0]                        bResp_reg;   // response code

	logic                              awFire;      // address handshake
	logic                              wFire;       // data handshake
	logic                              writeGo;     // both halves present
	logic [serial_irq_pkg::ADDR_W-1:0] wrAddr;      // effective address
	logic [serial_irq_pkg::DATA_W-1:0] wrData;      // effective data
	logic [serial_irq_pkg::STRB_W-1:0] wrStrb;      // effective strobes
	logic [serial_irq_pkg::REG_W-1:0]  laneMask;    // bits whose lane is on
	logic [serial_irq_pkg::REG_W-1:0]  wrBits;      // data under lanes
	logic                              wrPending;   // hit on pending reg
	logic                              wrEnable;    // hit on enable reg

	// each half is refused only while it is held or a response waits;
	// one write at a time keeps the response path trivial
	// limitation: a new write waits until bready has taken the response
	assign s_axi_awready = ~awHeld_reg & ~bValid_reg;
	assign s_axi_wready  = ~wHeld_reg & ~bValid_reg;
	assign awFire        = s_axi_awvalid & s_axi_awready;
	assign wFire         = s_axi_wvalid & s_axi_wready;
	assign writeGo       = (awHeld_reg | awFire) & (wHeld_reg | wFire);

	// take a half from the bus in this cycle or from its holding flops
	assign wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
	assign wrData = wHeld_reg ? wData_reg : s_axi_wdata;
	assign wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;

	// only the two low byte lanes reach the 16-bit registers
	// bit 15 is dropped by LIVE_BITS and never stored in either register
	assign laneMask = {{serial_irq_pkg::BYTE_W{wrStrb[serial_irq_pkg::LANE_HI]}},
	                   {serial_irq_pkg::BYTE_W{wrStrb[serial_irq_pkg::LANE_LO]}}};
	assign wrBits   = wrData[serial_irq_pkg::REG_W-1:0] & laneMask
	                  & serial_irq_pkg::LIVE_BITS;

	assign wrPending = writeGo & hitsReg(wrAddr, serial_irq_pkg::PENDING_OFFSET);
	assign wrEnable  = writeGo & hitsReg(wrAddr, serial_irq_pkg::ENABLE_OFFSET);

	// ones clear flags, zeros leave them alone
	// a lane whose strobe is low clears nothing
	assign clearVec = wrPending ? wrBits[serial_irq_pkg::EVT_N-1:0]
	                            : serial_irq_pkg::PENDING_RESET;

	// enable bits follow the written lanes, others keep their value
	// the new mask reaches irqOut one cycle after the write is taken
	assign enable_next = wrEnable
		? ((enable_reg & ~laneMask[serial_irq_pkg::EVT_N-1:0])
		   | wrBits[serial_irq_pkg::EVT_N-1:0])
		: enable_reg;

	// enable register
	// reset leaves every source masked off
	always_ff @(posedge ref_clk or negedge rstnSync_reg) begin
		if (!rstnSync_reg) begin
			enable_reg <= serial_irq_pkg::ENABLE_RESET;
		end else begin
			enable_reg <= enable_next;
		end
	end

	// holding flops for a half that arrives before the other
	// writeGo drops both held flags in the cycle the pair completes
	always_ff @(posedge ref_clk or negedge rstnSync_reg) begin
		if (!rstnSync_reg) begin
			awHeld_reg <= 1'b0;
			wHeld_reg  <= 1'b0;
		end else begin
			awHeld_reg <= (awHeld_reg | awFire) & ~writeGo;
			wHeld_reg  <= (wHeld_reg | wFire) & ~writeGo;
		end
	end

	// payload capture needs no reset; the held flags guard it
	// trade-off: less reset fan-out, unknown contents until first use
	always_ff @(posedge ref_clk) begin
		if (awFire) begin
			awAddr_reg <= s_axi_awaddr;
		end
		if (wFire) begin
			wData_reg <= s_axi_wdata;
			wStrb_reg <= s_axi_wstrb;
		end
	end

	// write response, one cycle after both halves are in
	// bresp is frozen while bvalid waits for bready
	always_ff @(posedge ref_clk or negedge rstnSync_reg) begin
		if (!rstnSync_reg) begin
			bValid_reg <= 1'b0;
			bResp_reg  <= serial_irq_pkg::RESP_OKAY;
		end else if (writeGo) begin
			bValid_reg <= 1'b1;
			// unmapped addresses are answered, never hung
			bResp_reg  <= (wrPending | wrEnable) ? serial_irq_pkg::RESP_OKAY
			                                     : serial_irq_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp  = bResp_reg;

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------

	logic                              rValid_reg;  // read data pending
	logic [serial_irq_pkg::DATA_W-1:0] rData_reg;   // registered read data
	logic [1:0]                        rResp_reg;   // read response code
	logic                              arFire;      // read handshake
	logic                              rdPending;   // hit on pending reg
	logic                              rdEnable;    // hit on enable reg
	logic [serial_irq_pkg::DATA_W-1:0] rdWord;      // selected word

	// a new read is taken only once the last one is consumed
	// reads have no side effect; a repeated read returns the same word
	assign s_axi_arready = ~rValid_reg;
	assign arFire        = s_axi_arvalid & s_axi_arready;
	assign rdPending     = hitsReg(s_axi_araddr, serial_irq_pkg::PENDING_OFFSET);
	assign rdEnable      = hitsReg(s_axi_araddr, serial_irq_pkg::ENABLE_OFFSET);

	// bit 15 and the upper half word always read zero
	// an unmapped word also reads zero, never stale data
	assign rdWord = rdPending ? {serial_irq_pkg::READ_ZERO[serial_irq_pkg::DATA_W-1:serial_irq_pkg::EVT_N],
	                             pendingFlags}
	              : rdEnable  ? {serial_irq_pkg::READ_ZERO[serial_irq_pkg::DATA_W-1:serial_irq_pkg::EVT_N],
	                             enable_reg}
	              : serial_irq_pkg::READ_ZERO;

	// read data and response, one cycle after the address
	// rdata comes from a flop, so it stands unchanged until rready
	always_ff @(posedge ref_clk or negedge rstnSync_reg) begin
		if (!rstnSync_reg) begin
			rValid_reg <= 1'b0;
			rData_reg  <= serial_irq_pkg::READ_ZERO;
			rResp_reg  <= serial_irq_pkg::RESP_OKAY;
		end else if (arFire) begin
			rValid_reg <= 1'b1;
			rData_reg  <= rdWord;
			rResp_reg  <= (rdPending | rdEnable) ? serial_irq_pkg::RESP_OKAY
			                                     : serial_irq_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rValid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rdata  = rData_reg;
	assign s_axi_rresp  = rResp_reg;

endmodule : serial_irq_ctrl

// File: core/serial_irq_pkg.sv
// Purpose: shared constants for the serial controller interrupt block
// Assumes: AXI4-Lite with 32-bit data, registers in the low 16 bits
// Notes:   offsets are byte addresses
package serial_irq_pkg;
	// bus geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int REG_W  = 16;
	localparam int EVT_N  = 15;

	// register byte addresses
	localparam logic [ADDR_W-1:0] PENDING_OFFSET = 16'h460c;
	localparam logic [ADDR_W-1:0] ENABLE_OFFSET  = 16'h4624;
	// low address bits that only pick a byte lane
	localparam logic [ADDR_W-1:0] WORD_MASK      = 16'hfffc;

	// event bit positions, shared by pending and enable
	localparam int BIT_UART_PARITY = 14;
	localparam int BIT_UART_FRAME  = 13;
	localparam int BIT_TX_B_UNLOAD = 12;
	localparam int BIT_TX_A_UNLOAD = 11;
	localparam int BIT_RX_B_UNLOAD = 10;
	localparam int BIT_RX_A_UNLOAD = 9;
	localparam int BIT_I2C_NAK     = 8;
	localparam int BIT_I2C_CMD     = 7;
	localparam int BIT_I2C_TX      = 6;
	localparam int BIT_I2C_RX      = 5;
	localparam int BIT_TX_UNDERRUN = 4;
	localparam int BIT_RX_OVERRUN  = 3;
	localparam int BIT_TX_IDLE     = 2;
	localparam int BIT_TX_FREE     = 1;
	localparam int BIT_RX_DATA     = 0;

	// reset values and the writable part of each register
	localparam logic [EVT_N-1:0]  PENDING_RESET = 15'h0000;
	localparam logic [EVT_N-1:0]  ENABLE_RESET  = 15'h0000;
	localparam logic [REG_W-1:0]  LIVE_BITS     = 16'h7fff;
	localparam logic [DATA_W-1:0] READ_ZERO     = 32'h0000_0000;

	// byte lanes that reach the 16-bit registers
	localparam int LANE_LO = 0;
	localparam int LANE_HI = 1;
	localparam int BYTE_W  = 8;   // bits per lane

	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : serial_irq_pkg

// File: core/event_flag_bank.sv
// Purpose: bank of sticky pending flags, one per event source
// Assumes: set and clear are synchronous to clk
// Notes:   a set in the same cycle as a clear wins
`timescale 1ns/10ps
module event_flag_bank (
	input  wire logic                           clk,
	input  wire logic                           rstn,
	input  wire logic [serial_irq_pkg::EVT_N-1:0] setIn,
	input  wire logic [serial_irq_pkg::EVT_N-1:0] clearIn,
	output logic      [serial_irq_pkg::EVT_N-1:0] flags
);
	// one flop per source; a generate keeps each bit independent
	for (genvar i = 0; i < serial_irq_pkg::EVT_N; i++) begin : gFlag
		logic flag_reg;   // sticky pending bit
		logic flag_next;  // its next value

		// set beats clear so an event arriving during a clear survives
		assign flag_next = setIn[i] | (flag_reg & ~clearIn[i]);

		// plain sticky flop, cleared only by reset or a clear
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				flag_reg <= serial_irq_pkg::PENDING_RESET[i];
			end else begin
				flag_reg <= flag_next;
			end
		end

		assign flags[i] = flag_reg;
	end
endmodule : event_flag_bank

// File: test/axi_cpu_model.sv
// Purpose: processor-side register master for the serial interrupt block
// Assumes: one write and one read at a time, changes just after a rising edge
// Notes:   answer-ready follows a random stall of 0 to 2 cycles
`timescale 1ns/10ps
module axi_cpu_model (
	input  wire logic        ref_clk,
	output logic      [15:0] s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic      [31:0] s_axi_wdata,
	output logic      [3:0]  s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic      [15:0] s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// idle bus from time zero
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 68'h0;
	end
	// one write; halves offered together, each dropped at its own acceptance
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic awOpen;
		logic wOpen;
		awOpen = 1'b1;
		wOpen = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (awOpen || wOpen) begin
			@(posedge ref_clk);
			if (awOpen && s_axi_awready) begin
				awOpen = 1'b0;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a; // released lines must not keep the old value
			end
			if (wOpen && s_axi_wready) begin
				wOpen = 1'b0;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end
		// a slow processor is as legal as a fast one
		repeat ($urandom_range(2)) @(posedge ref_clk);
		s_axi_bready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	// one read, data taken at the edge where rvalid is seen
	task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		repeat ($urandom_range(2)) @(posedge ref_clk);
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : axi_cpu_model

// File: test/serial_irq_ctrl_properties.sv
// Purpose: port-level checks of the serial interrupt block
// Assumes: one clock domain, reset active low
// Notes:   enable contents are unseen here, so irq checks bound change only
`timescale 1ns/10ps
module serial_irq_ctrl_properties (
	input wire logic        ref_clk,
	input wire logic        rstn,
	input wire logic        uart_parity_error_event,
	input wire logic        uart_framing_error_event,
	input wire logic        tx_buffer_b_unloaded_event,
	input wire logic        tx_buffer_a_unloaded_event,
	input wire logic        rx_buffer_b_unloaded_event,
	input wire logic        rx_buffer_a_unloaded_event,
	input wire logic        i2c_not_acknowledged_event,
	input wire logic        i2c_command_done_event,
	input wire logic        i2c_transmit_done_event,
	input wire logic        i2c_receive_done_event,
	input wire logic        transmit_underrun_event,
	input wire logic        receive_overrun_event,
	input wire logic        transmitter_idle_event,
	input wire logic        transmit_space_event,
	input wire logic        receive_data_event,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irqOut
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// any source high, or a write half accepted, may move the interrupt
	wire logic anyEvent = uart_parity_error_event | uart_framing_error_event | tx_buffer_b_unloaded_event
		| tx_buffer_a_unloaded_event | rx_buffer_b_unloaded_event | rx_buffer_a_unloaded_event
		| i2c_not_acknowledged_event | i2c_command_done_event | i2c_transmit_done_event | i2c_receive_done_event
		| transmit_underrun_event | receive_overrun_event | transmitter_idle_event | transmit_space_event
		| receive_data_event;
	wire logic wrMove = (s_axi_awvalid & s_axi_awready) | (s_axi_wvalid & s_axi_wready);
	// read address that hits either register
	wire logic arMapped = ((s_axi_araddr & serial_irq_pkg::WORD_MASK) == serial_irq_pkg::PENDING_OFFSET)
		| ((s_axi_araddr & serial_irq_pkg::WORD_MASK) == serial_irq_pkg::ENABLE_OFFSET);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_rd_stray;
		s_rd_take ##0 !arMapped;
	endsequence
	a_irq_sticky: assert property (irqOut && !wrMove |=> irqOut)
		else $error("interrupt dropped without a write");
	a_irq_quiet: assert property (!irqOut && !anyEvent && !wrMove |=> !irqOut)
		else $error("interrupt rose without cause");
	a_top_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0)
		else $error("read data above bit 14 not zero");
	a_write_answer: assert property (s_wr_both |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
		else $error("write response late");
	a_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	a_stray_read: assert property (s_rd_stray |=> s_axi_rresp == serial_irq_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
endmodule : serial_irq_ctrl_properties
bind serial_irq_ctrl serial_irq_ctrl_properties i_props (.*);

// File: test/serial_irq_ctrl_tb.sv
// Purpose: self-checking bench for the serial interrupt block
// Assumes: integer model of pending and enable, compared at every read
// Notes:   one scenario lands an event in the very cycle of its clear
`timescale 1ns/10ps
module serial_irq_ctrl_tb;
	logic        ref_clk, rstn, irqOut;
	logic [14:0] evt;                                        // event lines by bit position
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          pend, en, fails, checked, cycles, b, i, c;   // model state and counters
	localparam logic [15:0] PEND = serial_irq_pkg::PENDING_OFFSET;
	localparam logic [15:0] ENAB = serial_irq_pkg::ENABLE_OFFSET;
	localparam logic [1:0]  OK   = serial_irq_pkg::RESP_OKAY;
	serial_irq_ctrl i_dut (.uart_parity_error_event(evt[14]), .uart_framing_error_event(evt[13]),
		.tx_buffer_b_unloaded_event(evt[12]), .tx_buffer_a_unloaded_event(evt[11]),
		.rx_buffer_b_unloaded_event(evt[10]), .rx_buffer_a_unloaded_event(evt[9]),
		.i2c_not_acknowledged_event(evt[8]), .i2c_command_done_event(evt[7]), .i2c_transmit_done_event(evt[6]),
		.i2c_receive_done_event(evt[5]), .transmit_underrun_event(evt[4]), .receive_overrun_event(evt[3]),
		.transmitter_idle_event(evt[2]), .transmit_space_event(evt[1]), .receive_data_event(evt[0]), .*);
	axi_cpu_model i_cpu (.*);
	// 250 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// a hang counts as a mismatch
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// read, then compare data and response
	task automatic rdChk(input logic [15:0] a, input int e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		i_cpu.rd(a, d, r);
		chk("read data", d, 32'(e));
		chk("read resp", {30'h0, r}, {30'h0, er});
	endtask : rdChk
	task automatic wrChk(input logic [15:0] a, input int d, input logic [3:0] s, input logic [1:0] er);
		logic [1:0] r;
		i_cpu.wr(a, 32'(d), s, r);
		chk("write resp", {30'h0, r}, {30'h0, er});
	endtask : wrChk
	// one-cycle event pulse, folded into the model
	task automatic fire(input int v);
		evt <= 15'(v);
		@(posedge ref_clk);
		evt <= 15'h0000;
		pend = pend | (v & 'h7fff);
	endtask : fire
	task automatic irqChk();
		@(posedge ref_clk);
		chk("irq", {31'h0, irqOut}, 32'((pend & en) != 0));
	endtask : irqChk
	task automatic report_and_stop();
		if (fails == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		{rstn, evt, pend, en, fails, checked, cycles} = 0;
		c = $urandom(32'h05a890a7);
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rdChk(PEND, 0, OK);
		rdChk(ENAB, 0, OK);
		// every enable writable, bit 15 stays zero
		wrChk(ENAB, 'hffffffff, 4'hf, OK);
		en = 'h7fff;
		rdChk(ENAB, en, OK);
		// each source alone: flag position, interrupt, zero leaves it, one clears it
		for (b = 0; b < 15; b++) begin
			fire(1 << b);
			rdChk(PEND, 1 << b, OK);
			irqChk();
			wrChk(PEND, 0, 4'hf, OK);
			rdChk(PEND, 1 << b, OK);
			wrChk(PEND, 1 << b, 4'hf, OK);
			pend = 0;
			rdChk(PEND, 0, OK);
			irqChk();
		end
		// random masks against random event bursts and partial clears
		for (i = 0; i < 40; i++) begin
			c = $urandom;
			wrChk(ENAB, c, 4'hf, OK);
			en = c & 'h7fff;
			fire($urandom);
			irqChk();
			rdChk(PEND, pend, OK);
			c = $urandom;
			wrChk(PEND, c, 4'hf, OK);
			pend = pend & ~c;
			irqChk();
			rdChk(ENAB, en, OK);
		end
		// an event in the very cycle of its write-one clear survives
		evt <= 15'h0010;
		pend = pend | 'h10;
		fork
			begin
				@(posedge ref_clk);
				evt <= 15'h0000;
			end
			wrChk(PEND, 'h10, 4'hf, OK);
		join
		rdChk(PEND, pend, OK);
		// only the strobed low lane of enable changes
		wrChk(ENAB, 0, 4'h1, OK);
		en = en & 'h7f00;
		rdChk(ENAB | 16'h0002, en, OK);
		// address outside both registers is refused
		wrChk(16'h4600, 'h7fff, 4'hf, serial_irq_pkg::RESP_SLVERR);
		rdChk(16'h4600, 0, serial_irq_pkg::RESP_SLVERR);
		rdChk(ENAB, en, OK);
		report_and_stop();
	end
endmodule : serial_irq_ctrl_tb
